// [pirq_core_model.sv]
// ====================================================================
// core side: takes the active line and the non-maskable request
module pirq_core_model (
	// clock and reset
	input wire logic clock,
	input wire logic srst,
	// requests from the routing block
	input wire pirq_pkg::pirq_active_t active,
	input wire logic nmi_request,
	// what the core has taken
	output int nmi_count,
	output logic [4:0] last_line
);
	timeunit 1ns;
	timeprecision 1ps;

	// nmi is taken apart from the numbered lines, never through active
	always @(posedge clock) begin
		if (srst) begin
			nmi_count <= 0;
			last_line <= 5'h00;
		end else begin
			if (nmi_request) nmi_count <= nmi_count + 1;
			if (active.valid) last_line <= active.line;
		end
	end
endmodule

// [pirq_defines.svh]
`ifndef PIRQ_DEFINES_SVH
`define PIRQ_DEFINES_SVH

// ====================================================================
// interrupt line numbers
`define PIRQ_NUM_LINES 25
`define PIRQ_LINE_POWER_MANAGER 0
`define PIRQ_LINE_SYSTEM_CONTROL 1
`define PIRQ_LINE_WATCHDOG 2
`define PIRQ_LINE_REAL_TIME 3
`define PIRQ_LINE_EXTERNAL_IRQ 4
`define PIRQ_LINE_MEMORY_CONTROLLER 5
`define PIRQ_LINE_EVENT_SYSTEM 6
`define PIRQ_LINE_SERIAL_BASE 7
`define PIRQ_LINE_TIMER_BASE 13
`define PIRQ_LINE_ADC 21
`define PIRQ_LINE_ANALOG_COMPARATOR 22
`define PIRQ_LINE_DAC 23
`define PIRQ_LINE_TOUCH_CONTROLLER 24

// ====================================================================
// register offsets (byte addresses; the three per-peripheral ones are word indices)
`define PIRQ_PERIPH_STRIDE_LOG2 4
`define PIRQ_OFS_FLAG 2'h0
`define PIRQ_OFS_ENABLE_SET 2'h1
`define PIRQ_OFS_ENABLE_CLEAR 2'h2
`define PIRQ_OFS_PENDING_SET 12'h400
`define PIRQ_OFS_PENDING_CLEAR 12'h404
`define PIRQ_OFS_LINE_ENABLE_SET 12'h408
`define PIRQ_OFS_LINE_ENABLE_CLEAR 12'h40C
`define PIRQ_OFS_PRIORITY_BASE 12'h420
`define PIRQ_OFS_PRIORITY_LAST 12'h43C
`define PIRQ_OFS_STATUS 12'h440

// ====================================================================
// field positions and reset values
`define PIRQ_PRIO_LSB 6
`define PIRQ_PRIO_W 2
`define PIRQ_STATUS_VALID_BIT 8
`define PIRQ_RST_WORD 32'h0000_0000

`endif

// [pirq_pkg.sv]
package pirq_pkg;

	// ================================================================
	// which register an access selects
	typedef enum logic [3:0] {
		PIRQ_SEL_NONE,
		PIRQ_SEL_FLAG,
		PIRQ_SEL_ENABLE_SET,
		PIRQ_SEL_ENABLE_CLEAR,
		PIRQ_SEL_PENDING_SET,
		PIRQ_SEL_PENDING_CLEAR,
		PIRQ_SEL_LINE_ENABLE_SET,
		PIRQ_SEL_LINE_ENABLE_CLEAR,
		PIRQ_SEL_PRIORITY,
		PIRQ_SEL_STATUS
	} pirq_sel_t;

	// ================================================================
	// interrupt handed to the core
	typedef struct packed {
		logic valid;
		logic [4:0] line;
		logic [1:0] prio;
	} pirq_active_t;

endpackage

// [pirq_source_block.sv]
`include "pirq_defines.svh"

// flags and enables of one peripheral
module pirq_source_block #(
	parameter int SRC_W = 8
) (
	// clock and reset
	input wire logic clock,
	input wire logic srst,
	// source conditions
	input wire logic [SRC_W-1:0] event_in,
	// register writes
	input wire logic wr_flag_clear,
	input wire logic wr_enable_set,
	input wire logic wr_enable_clear,
	input wire logic [SRC_W-1:0] wdata,
	// state
	output logic [SRC_W-1:0] flag,
	output logic [SRC_W-1:0] enable,
	output logic req
);

	// ================================================================
	// next state: a new event beats a same-cycle clear
	logic [SRC_W-1:0] next_flag;
	logic [SRC_W-1:0] next_enable;
	assign next_flag = (flag & ~(wr_flag_clear ? wdata : '0)) | event_in; // see R01 see R14
	assign next_enable = wr_enable_set ? (enable | wdata) : // see R02
		wr_enable_clear ? (enable & ~wdata) : enable; // see R03

	// gated sources merged into one request
	assign req = |(flag & enable); // see R04 see R05

	// state registers
	always_ff @(posedge clock) begin
		if (srst) begin
			flag <= '0;
			enable <= '0;
		end else begin
			flag <= next_flag;
			enable <= next_enable;
		end
	end

	// ================================================================
	// checks
	a_flag_on_event: assert property (@(posedge clock) disable iff (srst) // see R01
		(event_in != '0) |=> ((flag & $past(event_in)) == $past(event_in)))
		else $error("event did not set its flag");
	a_flag_w1c: assert property (@(posedge clock) disable iff (srst) // see R14
		(wr_flag_clear && event_in == '0) |=>
		(flag == ($past(flag) & ~$past(wdata))))
		else $error("flag clear by writing one failed");
	a_enable_set: assert property (@(posedge clock) disable iff (srst) // see R02
		wr_enable_set |=> (enable == ($past(enable) | $past(wdata))))
		else $error("enable set misbehaved");
	a_enable_clear: assert property (@(posedge clock) disable iff (srst) // see R03
		(wr_enable_clear && !wr_enable_set) |=>
		(enable == ($past(enable) & ~$past(wdata))))
		else $error("enable clear misbehaved");
	a_req_gating: assert property (@(posedge clock) disable iff (srst) // see R04
		(event_in == '0 && !wr_flag_clear && !wr_enable_set && !wr_enable_clear && !req)
		|=> !req)
		else $error("request rose without a flag and enable");

endmodule

// [pirq_top.sv]
// Decided for this implementation: the register offsets and register access over Avalon-MM.
`include "pirq_defines.svh"

// Summary of operation
// R01: each source condition sets its own flag bit when it occurs
// R02: writing one to enable-set enables a source; zero leaves it alone
// R03: writing one to enable-clear disables a source; zero leaves it alone
// R04: a source requests only while both its flag and enable are set
// R05: all gated requests of one peripheral are ORed into one request
// R06: a peripheral request sets its line pending; software may set or clear pending
// R07: a pending line becomes active only while its line enable is set
// R08: one priority field per line, held in eight priority registers
// R09: the external controller's non-maskable source goes to the nmi output
// R10: system peripherals use fixed lines 0 through 6
// R11: six serial interfaces drive lines 7 to 12 in instance order
// R12: eight timer counters drive lines 13 to 20 in instance order
// R13: converter, comparator and touch peripherals use lines 21 to 24
// R14: writing one to a flag bit clears it; zero leaves it unchanged
module pirq_top #(
	parameter int SRC_W = 8
) (
	// clock and reset
	input wire logic clock,
	input wire logic srst,
	// avalon-mm slave
	input wire logic [11:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	// peripheral source conditions, one pulse per event
	input wire logic [6:0][SRC_W-1:0] sys_event,
	input wire logic [5:0][SRC_W-1:0] serial_event,
	input wire logic [7:0][SRC_W-1:0] timer_event,
	input wire logic [3:0][SRC_W-1:0] analog_event,
	input wire logic ext_nmi_event,
	// toward the core
	output pirq_pkg::pirq_active_t active,
	output logic nmi_request,
	output logic [31:0] line_request
);

	localparam int NL = `PIRQ_NUM_LINES;

	// ================================================================
	// line map: each peripheral event group lands on its fixed line
	logic [NL-1:0][SRC_W-1:0] line_event;
	assign line_event[`PIRQ_LINE_POWER_MANAGER] = sys_event[0]; // see R10
	assign line_event[`PIRQ_LINE_SYSTEM_CONTROL] = sys_event[1];
	assign line_event[`PIRQ_LINE_WATCHDOG] = sys_event[2];
	assign line_event[`PIRQ_LINE_REAL_TIME] = sys_event[3];
	assign line_event[`PIRQ_LINE_EXTERNAL_IRQ] = sys_event[4];
	assign line_event[`PIRQ_LINE_MEMORY_CONTROLLER] = sys_event[5];
	assign line_event[`PIRQ_LINE_EVENT_SYSTEM] = sys_event[6];
	assign line_event[`PIRQ_LINE_ADC] = analog_event[0]; // see R13
	assign line_event[`PIRQ_LINE_ANALOG_COMPARATOR] = analog_event[1];
	assign line_event[`PIRQ_LINE_DAC] = analog_event[2];
	assign line_event[`PIRQ_LINE_TOUCH_CONTROLLER] = analog_event[3];
	for (genvar s = 0; s < 6; s++) begin : gen_serial_map
		assign line_event[`PIRQ_LINE_SERIAL_BASE + s] = serial_event[s]; // see R11
	end
	for (genvar t = 0; t < 8; t++) begin : gen_timer_map
		assign line_event[`PIRQ_LINE_TIMER_BASE + t] = timer_event[t]; // see R12
	end

	// ================================================================
	// bus decode
	// a write takes effect on the edge where waitrequest is low; read data is captured on the edge before, while it is high
	logic bus_req;
	logic wr_ok;
	logic in_periph;
	logic [4:0] periph_idx;
	logic [1:0] periph_ofs;
	logic in_prio;
	logic [2:0] prio_idx;
	logic [31:0] be_mask;
	logic [31:0] wmask_data;
	pirq_pkg::pirq_sel_t sel;
	assign bus_req = read | write;
	assign wr_ok = write & ~waitrequest;
	assign periph_idx = address[`PIRQ_PERIPH_STRIDE_LOG2 +: 5];
	assign periph_ofs = address[3:2];
	assign in_periph = (address[11:9] == 3'h0) && (periph_idx < 5'(NL));
	assign in_prio = (address[11:2] >= `PIRQ_OFS_PRIORITY_BASE >> 2) &&
		(address[11:2] <= `PIRQ_OFS_PRIORITY_LAST >> 2);
	assign prio_idx = address[4:2];
	assign be_mask = {{8{byteenable[3]}}, {8{byteenable[2]}},
		{8{byteenable[1]}}, {8{byteenable[0]}}};
	// disabled byte lanes act as zeros, which every write-one register ignores
	assign wmask_data = writedata & be_mask;
	assign sel = (in_periph && periph_ofs == `PIRQ_OFS_FLAG) ? pirq_pkg::PIRQ_SEL_FLAG :
		(in_periph && periph_ofs == `PIRQ_OFS_ENABLE_SET) ? pirq_pkg::PIRQ_SEL_ENABLE_SET :
		(in_periph && periph_ofs == `PIRQ_OFS_ENABLE_CLEAR) ? pirq_pkg::PIRQ_SEL_ENABLE_CLEAR :
		(address == `PIRQ_OFS_PENDING_SET) ? pirq_pkg::PIRQ_SEL_PENDING_SET :
		(address == `PIRQ_OFS_PENDING_CLEAR) ? pirq_pkg::PIRQ_SEL_PENDING_CLEAR :
		(address == `PIRQ_OFS_LINE_ENABLE_SET) ? pirq_pkg::PIRQ_SEL_LINE_ENABLE_SET :
		(address == `PIRQ_OFS_LINE_ENABLE_CLEAR) ? pirq_pkg::PIRQ_SEL_LINE_ENABLE_CLEAR :
		in_prio ? pirq_pkg::PIRQ_SEL_PRIORITY :
		(address == `PIRQ_OFS_STATUS) ? pirq_pkg::PIRQ_SEL_STATUS :
		pirq_pkg::PIRQ_SEL_NONE;

	// ================================================================
	// peripheral flag and enable blocks
	logic [NL-1:0][SRC_W-1:0] src_flag;
	logic [NL-1:0][SRC_W-1:0] src_enable;
	logic [NL-1:0] periph_req;
	for (genvar p = 0; p < NL; p++) begin : gen_src
		logic hit;
		assign hit = wr_ok && in_periph && (periph_idx == 5'(p));
		pirq_source_block #(.SRC_W(SRC_W)) u_src (
			.clock(clock),
			.srst(srst),
			.event_in(line_event[p]),
			.wr_flag_clear(hit && sel == pirq_pkg::PIRQ_SEL_FLAG),
			.wr_enable_set(hit && sel == pirq_pkg::PIRQ_SEL_ENABLE_SET),
			.wr_enable_clear(hit && sel == pirq_pkg::PIRQ_SEL_ENABLE_CLEAR),
			.wdata(wmask_data[SRC_W-1:0]),
			.flag(src_flag[p]),
			.enable(src_enable[p]),
			.req(periph_req[p])
		);
	end

	// ================================================================
	// core-side pending, line enable and priority state
	logic [NL-1:0] pending;
	logic [NL-1:0] line_enable;
	logic [7:0][31:0] prio_reg;
	logic [NL-1:0] next_pending;
	logic [NL-1:0] next_line_enable;
	logic [NL-1:0] sw_pend_set;
	logic [NL-1:0] sw_pend_clear;
	logic [NL-1:0] sw_len_set;
	logic [NL-1:0] sw_len_clear;
	logic prio_wr;
	assign sw_pend_set = (wr_ok && sel == pirq_pkg::PIRQ_SEL_PENDING_SET) ?
		wmask_data[NL-1:0] : '0;
	assign sw_pend_clear = (wr_ok && sel == pirq_pkg::PIRQ_SEL_PENDING_CLEAR) ?
		wmask_data[NL-1:0] : '0;
	assign sw_len_set = (wr_ok && sel == pirq_pkg::PIRQ_SEL_LINE_ENABLE_SET) ?
		wmask_data[NL-1:0] : '0;
	assign sw_len_clear = (wr_ok && sel == pirq_pkg::PIRQ_SEL_LINE_ENABLE_CLEAR) ?
		wmask_data[NL-1:0] : '0;
	assign prio_wr = wr_ok && sel == pirq_pkg::PIRQ_SEL_PRIORITY;
	// a live peripheral request outranks a software clear of its pending bit
	assign next_pending = ((pending | sw_pend_set) & ~sw_pend_clear) | periph_req; // see R06
	assign next_line_enable = (line_enable | sw_len_set) & ~sw_len_clear; // see R07

	// pending and enable registers
	always_ff @(posedge clock) begin
		if (srst) begin
			pending <= '0;
			line_enable <= '0;
		end else begin
			pending <= next_pending;
			line_enable <= next_line_enable;
		end
	end

	// priority registers: only the field bits of each byte are kept
	logic [31:0] prio_keep;
	assign prio_keep = {4{8'(((1 << `PIRQ_PRIO_W) - 1) << `PIRQ_PRIO_LSB)}};
	always_ff @(posedge clock) begin
		if (srst) begin
			prio_reg <= {8{`PIRQ_RST_WORD}};
		end else if (prio_wr) begin
			prio_reg[prio_idx] <= (prio_reg[prio_idx] & ~be_mask) | // see R08
				(writedata & be_mask & prio_keep);
		end
	end

	// ================================================================
	// selection of the active line: lowest priority value, then lowest line
	logic [NL-1:0] ready_line;
	logic [NL-1:0][1:0] line_prio;
	pirq_pkg::pirq_active_t next_active;
	assign ready_line = pending & line_enable; // see R07
	for (genvar l = 0; l < NL; l++) begin : gen_prio_field
		assign line_prio[l] = prio_reg[l / 4][(l % 4) * 8 + `PIRQ_PRIO_LSB +: `PIRQ_PRIO_W];
	end

	// priority search over all lines
	always_comb begin
		next_active = '0;
		for (int l = NL - 1; l >= 0; l--) begin
			if (ready_line[l] && (!next_active.valid || line_prio[l] <= next_active.prio)) begin
				next_active.valid = 1'b1;
				next_active.line = 5'(l);
				next_active.prio = line_prio[l];
			end
		end
	end

	// outputs toward the core, all registered
	always_ff @(posedge clock) begin
		if (srst) begin
			active <= '0;
			nmi_request <= 1'b0;
			line_request <= '0;
		end else begin
			active <= next_active;
			nmi_request <= ext_nmi_event; // see R09
			line_request <= 32'(ready_line);
		end
	end

	// ================================================================
	// read mux and handshake; one wait cycle, then a one-cycle answer
	logic [31:0] rd_mux;
	logic [31:0] status_word;
	assign status_word = 32'({active.valid, 3'h0, active.line});
	assign rd_mux = (sel == pirq_pkg::PIRQ_SEL_FLAG) ? 32'(src_flag[periph_idx]) :
		(sel == pirq_pkg::PIRQ_SEL_ENABLE_SET ||
		sel == pirq_pkg::PIRQ_SEL_ENABLE_CLEAR) ? 32'(src_enable[periph_idx]) :
		(sel == pirq_pkg::PIRQ_SEL_PENDING_SET ||
		sel == pirq_pkg::PIRQ_SEL_PENDING_CLEAR) ? 32'(pending) :
		(sel == pirq_pkg::PIRQ_SEL_LINE_ENABLE_SET ||
		sel == pirq_pkg::PIRQ_SEL_LINE_ENABLE_CLEAR) ? 32'(line_enable) :
		(sel == pirq_pkg::PIRQ_SEL_PRIORITY) ? prio_reg[prio_idx] :
		(sel == pirq_pkg::PIRQ_SEL_STATUS) ? status_word :
		`PIRQ_RST_WORD;

	// the answer cycle always drops back to waiting, so requests never chain
	always_ff @(posedge clock) begin
		if (srst) begin
			waitrequest <= 1'b1;
			readdata <= `PIRQ_RST_WORD;
		end else begin
			waitrequest <= !(bus_req && waitrequest);
			readdata <= (bus_req && waitrequest) ? rd_mux : readdata;
		end
	end

	// ================================================================
	// checks
	a_pending_from_req: assert property (@(posedge clock) disable iff (srst) // see R06
		(periph_req != '0) |=> ((pending & $past(periph_req)) == $past(periph_req)))
		else $error("peripheral request did not set pending");
	a_sw_pend_clear: assert property (@(posedge clock) disable iff (srst) // see R06
		(sw_pend_clear != '0 && periph_req == '0 && sw_pend_set == '0) |=>
		((pending & $past(sw_pend_clear)) == '0))
		else $error("software pending clear failed");
	// the line index is today's; only the pending and enable words come from the past
	a_active_enabled: assert property (@(posedge clock) disable iff (srst) // see R07
		active.valid |-> (($past(pending & line_enable) & (NL'(1) << active.line)) != '0))
		else $error("active line was not pending and enabled");
	a_nmi_route: assert property (@(posedge clock) disable iff (srst) // see R09
		ext_nmi_event |=> nmi_request ##1 (nmi_request == $past(ext_nmi_event)))
		else $error("nmi source not routed to nmi output");
	a_prio_write: assert property (@(posedge clock) disable iff (srst) // see R08
		(prio_wr && byteenable == 4'hF) |=>
		(prio_reg[$past(prio_idx)] == ($past(writedata) & prio_keep)))
		else $error("priority register write lost");
	a_map_watchdog: assert property (@(posedge clock) disable iff (srst) // see R10
		(sys_event[2] != '0) |=> (src_flag[2] != '0))
		else $error("watchdog source not on line 2");
	a_map_serial: assert property (@(posedge clock) disable iff (srst) // see R11
		(serial_event[5] != '0) |=> (src_flag[12] != '0))
		else $error("last serial instance not on line 12");
	a_map_timer: assert property (@(posedge clock) disable iff (srst) // see R12
		(timer_event[0] != '0) |=> (src_flag[13] != '0))
		else $error("first timer not on line 13");
	a_map_touch: assert property (@(posedge clock) disable iff (srst) // see R13
		(analog_event[3] != '0) |=> (src_flag[24] != '0))
		else $error("touch controller not on line 24");
	a_bus_answer: assert property (@(posedge clock) disable iff (srst)
		(bus_req && waitrequest) |=> !waitrequest ##1 waitrequest)
		else $error("bus answer not one cycle after request");

	// both ends of each line group, so a shifted map cannot slip through
	a_map_power: assert property (@(posedge clock) disable iff (srst) // see R10
		(sys_event[0] != '0) |=> (src_flag[0] != '0))
		else $error("power manager not on line 0");
	a_map_events: assert property (@(posedge clock) disable iff (srst) // see R10
		(sys_event[6] != '0) |=> (src_flag[6] != '0))
		else $error("event system not on line 6");
	a_map_serial_first: assert property (@(posedge clock) disable iff (srst) // see R11
		(serial_event[0] != '0) |=> (src_flag[7] != '0))
		else $error("first serial instance not on line 7");
	a_map_timer_last: assert property (@(posedge clock) disable iff (srst) // see R12
		(timer_event[7] != '0) |=> (src_flag[20] != '0))
		else $error("last timer not on line 20");
	a_map_adc: assert property (@(posedge clock) disable iff (srst) // see R13
		(analog_event[0] != '0) |=> (src_flag[21] != '0))
		else $error("converter not on line 21");

	// software side of the pending and line enable words
	a_pend_sw_set: assert property (@(posedge clock) disable iff (srst) // see R06
		(sw_pend_set != '0 && sw_pend_clear == '0) |=>
		((pending & $past(sw_pend_set)) == $past(sw_pend_set)))
		else $error("software pending set failed");
	a_line_en_set: assert property (@(posedge clock) disable iff (srst) // see R07
		(sw_len_set != '0 && sw_len_clear == '0) |=>
		((line_enable & $past(sw_len_set)) == $past(sw_len_set)))
		else $error("line enable set failed");
	a_line_en_clear: assert property (@(posedge clock) disable iff (srst) // see R07
		(sw_len_clear != '0) |=> ((line_enable & $past(sw_len_clear)) == '0))
		else $error("line enable clear failed");

	// a ready line is always offered, and nothing is offered without one
	a_active_follows: assert property (@(posedge clock) disable iff (srst) // see R07
		(ready_line != '0) |=> active.valid)
		else $error("ready line not offered to the core");
	a_idle_no_active: assert property (@(posedge clock) disable iff (srst) // see R07
		(ready_line == '0) |=> !active.valid)
		else $error("active offered with no ready line");

endmodule

// [pirq_top_tb_top.sv]
module pirq_top_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int SRC_W = 8;
	logic clock, srst, read, write, waitrequest, ext_nmi_event, nmi_request;
	logic [11:0] address;
	logic [31:0] writedata, readdata, line_request, pend_m, len_m;
	logic [3:0] byteenable;
	logic [24:0][SRC_W-1:0] ev;
	logic [4:0] last_line;
	pirq_pkg::pirq_active_t active;
	int miscompares, samples_checked, nmi_count, b;
	int flag_m[32], en_m[32], prio_m[32];
	integer seed;

	// ================================================================
	// design and core model; ev index equals the expected line number
	pirq_top #(.SRC_W(SRC_W)) dut (.clock(clock), .srst(srst), .address(address),
		.read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
		.readdata(readdata), .waitrequest(waitrequest), .sys_event(ev[6:0]),
		.serial_event(ev[12:7]), .timer_event(ev[20:13]), .analog_event(ev[24:21]),
		.ext_nmi_event(ext_nmi_event), .active(active), .nmi_request(nmi_request),
		.line_request(line_request));
	pirq_core_model core (.clock(clock), .srst(srst), .active(active),
		.nmi_request(nmi_request), .nmi_count(nmi_count), .last_line(last_line));

	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end

	// ================================================================
	// reference model
	function logic [7:0] exp_act();
		logic [31:0] r;
		int best;
		r = pend_m & len_m;
		best = -1;
		for (int l = 0; l < 25; l++) if (r[l] && (best < 0 || prio_m[l] < prio_m[best])) best = l;
		return (best < 0) ? 8'h00 : {1'b1, 5'(best), 2'(prio_m[best])};
	endfunction
	function void mupd();
		for (int l = 0; l < 25; l++) if ((flag_m[l] & en_m[l]) != 0) pend_m[l] = 1'b1;
	endfunction
	function logic [31:0] mrd(input logic [11:0] a);
		logic [31:0] v;
		logic [7:0] t;
		v = 32'h0;
		t = exp_act();
		if (a < 12'h190) begin
			if (a[3:2] == 2'h0) v = flag_m[a >> 4];
			else if (a[3:2] != 2'h3) v = en_m[a >> 4];
		end else if (a == 12'h400 || a == 12'h404) v = pend_m;
		else if (a == 12'h408 || a == 12'h40C) v = len_m;
		else if (a >= 12'h420 && a <= 12'h43C) begin
			for (int k = 0; k < 4; k++) v[8*k+6 +: 2] = 2'(prio_m[((a - 12'h420) >> 2) * 4 + k]);
		end else if (a == 12'h440) v = {23'h0, t[7], 3'h0, t[6:2]};
		return v;
	endfunction
	function void mwr(input logic [11:0] a, input logic [31:0] d);
		int p;
		int r;
		p = a >> 4;
		r = (a - 12'h420) >> 2;
		if (a < 12'h190 && a[3:2] == 2'h0) flag_m[p] &= ~d;
		else if (a < 12'h190 && a[3:2] == 2'h1) en_m[p] |= d & 255;
		else if (a < 12'h190 && a[3:2] == 2'h2) en_m[p] &= ~d;
		else if (a == 12'h400) pend_m |= d & 32'h01FF_FFFF;
		else if (a == 12'h404) pend_m &= ~d;
		else if (a == 12'h408) len_m |= d & 32'h01FF_FFFF;
		else if (a == 12'h40C) len_m &= ~d;
		else if (a >= 12'h420 && a <= 12'h43C) begin
			for (int k = 0; k < 4; k++) prio_m[4*r+k] = d[8*k+6 +: 2];
		end
	endfunction

	// ================================================================
	// compares, bus cycle, stimulus helpers
	task chk_rd(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			$display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
			miscompares++;
		end
	endtask
	task chk_pin(input logic [31:0] got, input logic [31:0] exp);
		chk_rd(got, exp);
	endtask
	// request held until waitrequest is seen low; only the watchdog ends a dead wait
	task acc(input logic wr, input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		@(posedge clock);
		address <= a;
		write <= wr;
		read <= ~wr;
		writedata <= d;
		do begin
			@(posedge clock);
		end while (waitrequest !== 1'b0);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
		if (wr) mwr(a, d);
		else chk_rd(q, mrd(a));
		mupd();
	endtask
	task pulse(input int p, input logic [7:0] bits);
		@(posedge clock);
		ev[p] <= bits;
		@(posedge clock);
		ev[p] <= '0;
		flag_m[p] |= bits;
	endtask
	// pending, active and the core's last_line take three edges; one spare
	task settle();
		repeat (4) @(posedge clock);
		mupd();
	endtask
	task tally_and_finish();
		$display("compares %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	// ================================================================
	// main sequence
	initial begin
		seed = 32'hD4BB;
		{srst, read, write, address, writedata, ext_nmi_event} = {1'b1, 47'h0};
		byteenable = 4'hF;
		ev = '0;
		{pend_m, len_m, miscompares, samples_checked} = '0;
		for (int l = 0; l < 32; l++) {flag_m[l], en_m[l], prio_m[l]} = '0;
		repeat (11) @(posedge clock);
		chk_pin({22'h0, nmi_request, waitrequest, active}, {22'h0, 2'h1, 8'h00});
		chk_pin(line_request, 32'h0);
		chk_pin(readdata, 32'h0);
		@(posedge clock);
		srst <= 1'b0;
		acc(0, 12'h440, 0);
		$display("test reset done");
		for (int p = 0; p < 25; p++) begin
			b = $random(seed) & 7;
			acc(1, 12'(p*16+4), 32'h1 << b);
			acc(1, 12'h408, 32'h1 << p);
			pulse(p, 8'h1 << b);
			settle();
			chk_pin(line_request, 32'h1 << p);
			chk_pin(line_request, pend_m & len_m);
			chk_pin({24'h0, active}, {24'h0, exp_act()});
			chk_pin({27'h0, last_line}, p);
			acc(0, 12'(p*16), 0);
			acc(0, 12'(p*16+8), 0);
			acc(1, 12'(p*16), 32'h0);
			acc(0, 12'(p*16), 0);
			acc(1, 12'(p*16), 32'hFF);
			acc(1, 12'(p*16+8), 32'hFF);
			acc(1, 12'h404, 32'h1 << p);
			acc(1, 12'h40C, 32'h1 << p);
			settle();
			chk_pin(line_request, 32'h0);
		end
		$display("test line mapping done");
		pulse(13, 8'h24);
		settle();
		acc(0, 12'h0D0, 0);
		acc(0, 12'h400, 0);
		acc(1, 12'h0D4, 32'h0);
		acc(0, 12'h0D4, 0);
		acc(1, 12'h0D4, 32'h20);
		settle();
		acc(0, 12'h400, 0);
		chk_pin(line_request, 32'h0);
		chk_pin({24'h0, active}, 32'h0);
		acc(1, 12'h0D8, 32'h0);
		acc(0, 12'h0D8, 0);
		acc(1, 12'h0D8, 32'h20);
		acc(1, 12'h404, 32'h2000);
		settle();
		acc(0, 12'h404, 0);
		acc(1, 12'h400, 32'h0020_0000);
		acc(1, 12'h408, 32'h0020_0000);
		settle();
		chk_pin(line_request, 32'h0020_0000);
		acc(0, 12'h440, 0);
		acc(1, 12'h7F0, 32'hFFFF_FFFF);
		acc(0, 12'h7F0, 0);
		acc(0, 12'h0DC, 0);
		acc(1, 12'h0D0, 32'hFF);
		acc(1, 12'h404, 32'hFFFF_FFFF);
		acc(1, 12'h40C, 32'hFFFF_FFFF);
		$display("test gating done");
		for (int i = 0; i < 4; i++) begin
			for (int r = 0; r < 8; r++) acc(1, 12'h420 + 12'(4*r), $random(seed));
			for (int r = 0; r < 8; r++) acc(0, 12'h420 + 12'(4*r), 0);
			acc(1, 12'h400, $random(seed));
			acc(1, 12'h408, $random(seed));
			settle();
			chk_pin(line_request, pend_m & len_m);
			chk_pin({24'h0, active}, {24'h0, exp_act()});
			acc(0, 12'h440, 0);
			acc(0, 12'h408, 0);
			acc(0, 12'h40C, 0);
			acc(1, 12'h404, 32'hFFFF_FFFF);
			acc(1, 12'h40C, 32'hFFFF_FFFF);
		end
		$display("test priority done");
		@(posedge clock);
		ext_nmi_event <= 1'b1;
		@(posedge clock);
		ext_nmi_event <= 1'b0;
		@(posedge clock);
		chk_pin(nmi_request, 32'h1);
		chk_pin(line_request, 32'h0);
		@(posedge clock);
		chk_pin(nmi_request, 32'h0);
		chk_pin(nmi_count, 32'h1);
		$display("test nmi done");
		tally_and_finish();
	end

	// tests need about 1400 cycles; twenty times that means a hang
	initial begin
		repeat (30000) @(posedge clock);
		miscompares++;
		tally_and_finish();
	end
endmodule
